//--- design/pmr_phy_mgmt_regs.v
`timescale 1ns/1ns
// Notes on behaviour
// - station addresses 1..5 select ports 1..5
// - only register selects 0..5 exist per port
// - same registers also reachable through spi slave
// - control bit 15 soft-resets the port
// - control bit 14 selects mac-side loopback
// - bit 12 autoneg; else bits 13, 8 force
// - control bit 9 restarts autonegotiation
// - control bit 11 powers the port down
// - control bit 10 isolates the transmit pair
// - control bit 4 forces straight mdi
// - control bit 3 disables auto crossover
// - control bit 2 disables far end fault
// - bit 1 disables transmit, bit 0 leds
// - status bit 4 shows far end fault
// - status bit 5 an done, bit 2 link
// - status bits 14..11 and 3 read one
// - unsupported status bits read zero
// - registers 2, 3 hold fixed identifier
// - advert bits 10, 8..5 writable, selector 00001
// - clearing advert bit 10 withdraws pause
// - register 5 reports partner abilities
// - next page, remote fault, ack read zero
`include "pmr_map.vh"

module pmr_phy_mgmt_regs #(
  parameter [15:0] PHY_ID_HI = 16'hA5A5, // arbitrary value
  parameter [15:0] PHY_ID_LO = 16'h5A50  // arbitrary value
) (
  input  wire        I_SYS_CLK,
  input  wire        I_NRST,
  input  wire        I_MDC,
  input  wire        I_MDIO_IN,
  output reg         O_MDIO_OUT,
  output reg         O_MDIO_OE_N,
  input  wire        I_SPI_SCK,
  input  wire        I_SPI_SS_N,
  input  wire        I_SPI_MOSI,
  output wire        O_SPI_MISO,
  output reg         O_SPI_MISO_OE_N,
  input  wire [4:0]  I_LINK_UP,
  input  wire [4:0]  I_AN_DONE,
  input  wire [4:0]  I_FAR_FAULT,
  input  wire [24:0] I_LP_ABIL,
  input  wire [4:0]  I_NEG_SPEED_100,
  input  wire [4:0]  I_NEG_FULL_DPX,
  output reg  [4:0]  O_SOFT_RST,
  output reg  [4:0]  O_AN_RESTART,
  output wire [4:0]  O_LOOPBACK,
  output wire [4:0]  O_AN_ENABLE,
  output wire [4:0]  O_PWR_DOWN,
  output wire [4:0]  O_ISOLATE,
  output wire [4:0]  O_FORCE_MDI,
  output wire [4:0]  O_AUTO_MDIX_DIS,
  output wire [4:0]  O_FEF_DIS,
  output wire [4:0]  O_TX_DIS,
  output wire [4:0]  O_LED_DIS,
  output reg  [4:0]  O_SPEED_100,
  output reg  [4:0]  O_FULL_DPX,
  output wire [24:0] O_ADV_ABIL
);

  reg  [79:0] ctrl_q;
  reg  [79:0] adv_q;

  // ---------------------------------------------------------------
  // address check and read decode
  // ---------------------------------------------------------------
  function addr_ok;
    input [4:0] port;
    input [4:0] regn;
    begin
      addr_ok = (port >= `PMR_PORT_FIRST) && (port <= `PMR_PORT_LAST) &&
                (regn <= `PMR_REG_LAST);
    end
  endfunction

  function [15:0] rd_word;
    input [4:0] port;
    input [2:0] regn;
    reg   [2:0]  idx;
    reg   [15:0] ctl;
    reg   [4:0]  lp;
    begin
      idx = port[2:0] - 3'h1;
      ctl = ctrl_q[idx*16 +: 16];
      lp  = I_LP_ABIL[idx*5 +: 5];
      case (regn)
        `PMR_REG_CTRL: rd_word = ctl;
        `PMR_REG_STAT: begin
          rd_word = `PMR_STAT_CAPS;
          rd_word[`PMR_SB_ANDONE] = I_AN_DONE[idx];
          rd_word[`PMR_SB_FEF] = I_FAR_FAULT[idx] & ~ctl[`PMR_CB_NOFEF];
          rd_word[`PMR_SB_LINK] = I_LINK_UP[idx];
        end
        `PMR_REG_IDH: rd_word = PHY_ID_HI;
        `PMR_REG_IDL: rd_word = PHY_ID_LO;
        `PMR_REG_ADV: rd_word = adv_q[idx*16 +: 16] | `PMR_ADV_SEL;
        `PMR_REG_LPA: begin
          rd_word = `PMR_ADV_SEL;
          rd_word[`PMR_AB_PAUSE] = lp[4];
          rd_word[`PMR_AB_LO +: 4] = lp[3:0];
        end
        default: rd_word = 16'h0000;
      endcase
      if (!addr_ok(port, {2'b00, regn}))
        rd_word = 16'h0000;
    end
  endfunction

  // ---------------------------------------------------------------
  // serial management side
  // ---------------------------------------------------------------
  reg  [2:0]  mdc_s;
  reg  [1:0]  mdio_s;
  reg  [5:0]  md_pre;
  reg  [5:0]  md_cnt;
  reg  [15:0] md_sh;
  reg  [15:0] md_tx;
  reg         md_act;
  reg         md_rd;
  reg  [4:0]  md_port;
  reg  [4:0]  md_reg;
  reg         md_wr;
  reg  [15:0] md_wdata;

  wire        mdc_rise = mdc_s[1] & ~mdc_s[2];
  wire        md_bit   = mdio_s[1];
  wire [15:0] md_word  = {md_sh[14:0], md_bit};
  wire [13:0] md_hdr   = md_word[13:0];
  wire        md_hit   = (md_hdr[13:12] == `PMR_MD_ST) &&
                         ((md_hdr[11:10] == `PMR_MD_OP_RD) ||
                          (md_hdr[11:10] == `PMR_MD_OP_WR)) &&
                         (md_hdr[9:5] >= `PMR_PORT_FIRST) &&
                         (md_hdr[9:5] <= `PMR_PORT_LAST);

  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      mdc_s  <= 3'h0;
      mdio_s <= 2'h0;
    end else begin
      mdc_s  <= {mdc_s[1:0], I_MDC};
      mdio_s <= {mdio_s[0], I_MDIO_IN};
    end
  end

  // outputs change just after the sampled rising edge, well before the next
  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      md_pre      <= 6'd0;
      md_cnt      <= 6'd0;
      md_sh       <= 16'h0000;
      md_tx       <= 16'h0000;
      md_act      <= 1'b0;
      md_rd       <= 1'b0;
      md_port     <= 5'h00;
      md_reg      <= 5'h00;
      md_wr       <= 1'b0;
      md_wdata    <= 16'h0000;
      O_MDIO_OUT  <= 1'b1;
      O_MDIO_OE_N <= 1'b1;
    end else begin
      md_wr <= 1'b0;
      if (mdc_rise) begin
        if (md_cnt == 6'd0) begin
          // no preamble suppression: a full run of ones precedes each frame
          if (md_bit) begin
            if (md_pre != `PMR_MD_PRE)
              md_pre <= md_pre + 6'd1;
          end else begin
            if (md_pre == `PMR_MD_PRE)
              md_cnt <= 6'd1;
            md_pre <= 6'd0;
          end
          md_sh <= 16'h0000;
        end else begin
          md_sh  <= md_word;
          md_cnt <= md_cnt + 6'd1;
          if (md_cnt == `PMR_MD_HDR_LAST) begin
            md_act  <= md_hit;
            md_rd   <= (md_hdr[11:10] == `PMR_MD_OP_RD);
            md_port <= md_hdr[9:5];
            md_reg  <= md_hdr[4:0];
            // rd_word only sees three select bits, so screen the full select here
            md_tx   <= addr_ok(md_hdr[9:5], md_hdr[4:0]) ?
                       rd_word(md_hdr[9:5], md_hdr[2:0]) : 16'h0000;
          end
          if (md_act && md_rd) begin
            if (md_cnt == `PMR_MD_TA_LAST) begin
              O_MDIO_OE_N <= 1'b0;
              O_MDIO_OUT  <= 1'b0;
            end else if (md_cnt > `PMR_MD_TA_LAST && md_cnt <= `PMR_MD_D0_LAST) begin
              O_MDIO_OUT <= md_tx[15];
              md_tx      <= {md_tx[14:0], 1'b0};
            end
          end
          if (md_cnt == `PMR_MD_END) begin
            md_cnt      <= 6'd0;
            md_act      <= 1'b0;
            O_MDIO_OE_N <= 1'b1;
            O_MDIO_OUT  <= 1'b1;
            if (md_act && !md_rd && addr_ok(md_port, md_reg)) begin
              md_wr    <= 1'b1;
              md_wdata <= md_word;
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // spi side: cmd byte, address {0,port,reg,low}, one data byte
  // ---------------------------------------------------------------
  reg  [2:0]  sck_s;
  reg  [1:0]  ss_s;
  reg  [1:0]  mosi_s;
  reg  [4:0]  sp_cnt;
  reg  [15:0] sp_sh;
  reg  [7:0]  sp_cmd;
  reg  [7:0]  sp_addr;
  reg  [7:0]  sp_tx;
  reg         sp_wr;
  reg  [15:0] sp_wdata;

  wire        sck_rise = sck_s[1] & ~sck_s[2];
  wire        sck_fall = ~sck_s[1] & sck_s[2];
  wire        ss_act   = ~ss_s[1];
  wire [15:0] sp_word  = {sp_sh[14:0], mosi_s[1]};
  wire [4:0]  sp_port  = {2'b00, sp_addr[6:4]};
  wire [15:0] sp_cur   = rd_word(sp_port, sp_addr[3:1]);
  wire [15:0] sp_rdw   = rd_word({2'b00, sp_word[6:4]}, sp_word[3:1]);

  assign O_SPI_MISO = sp_tx[7];

  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sck_s  <= 3'h0;
      ss_s   <= 2'h3;
      mosi_s <= 2'h0;
    end else begin
      sck_s  <= {sck_s[1:0], I_SPI_SCK};
      ss_s   <= {ss_s[0], I_SPI_SS_N};
      mosi_s <= {mosi_s[0], I_SPI_MOSI};
    end
  end

  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sp_cnt          <= 5'd0;
      sp_sh           <= 16'h0000;
      sp_cmd          <= 8'h00;
      sp_addr         <= 8'h00;
      sp_tx           <= 8'h00;
      sp_wr           <= 1'b0;
      sp_wdata        <= 16'h0000;
      O_SPI_MISO_OE_N <= 1'b1;
    end else begin
      sp_wr           <= 1'b0;
      O_SPI_MISO_OE_N <= ~ss_act;
      if (!ss_act) begin
        sp_cnt <= 5'd0;
        sp_tx  <= 8'h00;
      end else if (sck_rise) begin
        sp_sh <= sp_word;
        if (sp_cnt != `PMR_SPI_SAT)
          sp_cnt <= sp_cnt + 5'd1;
        if (sp_cnt == `PMR_SPI_HDR_LAST) begin
          sp_cmd  <= sp_word[15:8];
          sp_addr <= sp_word[7:0];
          if (sp_word[15:8] == `PMR_SPI_RD)
            sp_tx <= sp_word[0] ? sp_rdw[7:0] : sp_rdw[15:8];
        end
        if (sp_cnt == `PMR_SPI_END && sp_cmd == `PMR_SPI_WR &&
            addr_ok(sp_port, {2'b00, sp_addr[3:1]})) begin
          sp_wr    <= 1'b1;
          sp_wdata <= sp_addr[0] ? {sp_cur[15:8], sp_word[7:0]}
                                 : {sp_word[7:0], sp_cur[7:0]};
        end
      end else if (sck_fall && sp_cnt >= `PMR_SPI_DAT_1ST) begin
        sp_tx <= {sp_tx[6:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // write merge: serial management wins a same-cycle clash
  // ---------------------------------------------------------------
  wire        wr_en   = md_wr | sp_wr;
  wire [4:0]  wr_port = md_wr ? md_port : sp_port;
  wire [2:0]  wr_reg  = md_wr ? md_reg[2:0] : sp_addr[3:1];
  wire [15:0] wr_data = md_wr ? md_wdata : sp_wdata;

  // ---------------------------------------------------------------
  // per-port register storage
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : port_regs
      wire [15:0] ctl = ctrl_q[g*16 +: 16];
      wire        sel = wr_en && (wr_port == g + 1);

      always @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
          ctrl_q[g*16 +: 16] <= `PMR_CTRL_RST;
          adv_q[g*16 +: 16]  <= `PMR_ADV_RST;
          O_SOFT_RST[g]      <= 1'b0;
          O_AN_RESTART[g]    <= 1'b0;
          O_SPEED_100[g]     <= 1'b0;
          O_FULL_DPX[g]      <= 1'b0;
        end else begin
          O_SOFT_RST[g]   <= 1'b0;
          O_AN_RESTART[g] <= 1'b0;
          if (sel && wr_reg == `PMR_REG_CTRL) begin
            if (wr_data[`PMR_CB_SRST]) begin
              ctrl_q[g*16 +: 16] <= `PMR_CTRL_RST;
              adv_q[g*16 +: 16]  <= `PMR_ADV_RST;
              O_SOFT_RST[g]      <= 1'b1;
            end else begin
              ctrl_q[g*16 +: 16] <= wr_data & `PMR_CTRL_WMASK;
              O_AN_RESTART[g]    <= wr_data[`PMR_CB_RSTAN];
            end
          end else if (sel && wr_reg == `PMR_REG_ADV) begin
            adv_q[g*16 +: 16] <= wr_data & `PMR_ADV_WMASK;
          end
          // forced values only apply while negotiation is off
          O_SPEED_100[g] <= ctl[`PMR_CB_ANEN] ? I_NEG_SPEED_100[g]
                                              : ctl[`PMR_CB_F100];
          O_FULL_DPX[g]  <= ctl[`PMR_CB_ANEN] ? I_NEG_FULL_DPX[g]
                                              : ctl[`PMR_CB_FFDX];
        end
      end

      assign O_LOOPBACK[g]      = ctl[`PMR_CB_LOOP];
      assign O_AN_ENABLE[g]     = ctl[`PMR_CB_ANEN];
      assign O_PWR_DOWN[g]      = ctl[`PMR_CB_PDN];
      assign O_ISOLATE[g]       = ctl[`PMR_CB_ISO];
      assign O_FORCE_MDI[g]     = ctl[`PMR_CB_FMDI];
      assign O_AUTO_MDIX_DIS[g] = ctl[`PMR_CB_NOMDIX];
      assign O_FEF_DIS[g]       = ctl[`PMR_CB_NOFEF];
      assign O_TX_DIS[g]        = ctl[`PMR_CB_NOTX];
      assign O_LED_DIS[g]       = ctl[`PMR_CB_NOLED];
      // order per port: pause, 100 full, 100 half, 10 full, 10 half
      assign O_ADV_ABIL[g*5 + 4]   = adv_q[g*16 + `PMR_AB_PAUSE];
      assign O_ADV_ABIL[g*5 +: 4]  = adv_q[g*16 + `PMR_AB_LO +: 4];
    end
  endgenerate

endmodule

//--- design/pmr_map.vh
`ifndef PMR_MAP_VH
`define PMR_MAP_VH

// ---------------------------------------------------------------
// register selects
// ---------------------------------------------------------------
`define PMR_REG_CTRL     3'h0
`define PMR_REG_STAT     3'h1
`define PMR_REG_IDH      3'h2
`define PMR_REG_IDL      3'h3
`define PMR_REG_ADV      3'h4
`define PMR_REG_LPA      3'h5
`define PMR_REG_LAST     5'h05

// ---------------------------------------------------------------
// station addresses
// ---------------------------------------------------------------
`define PMR_PORT_FIRST   5'h01
`define PMR_PORT_LAST    5'h05

// ---------------------------------------------------------------
// control word fields
// ---------------------------------------------------------------
`define PMR_CB_SRST      15
`define PMR_CB_LOOP      14
`define PMR_CB_F100      13
`define PMR_CB_ANEN      12
`define PMR_CB_PDN       11
`define PMR_CB_ISO       10
`define PMR_CB_RSTAN     9
`define PMR_CB_FFDX      8
`define PMR_CB_FMDI      4
`define PMR_CB_NOMDIX    3
`define PMR_CB_NOFEF     2
`define PMR_CB_NOTX      1
`define PMR_CB_NOLED     0
`define PMR_CTRL_WMASK   16'h7D1F
`define PMR_CTRL_RST     16'h3000

// ---------------------------------------------------------------
// status, advertisement and partner fields
// ---------------------------------------------------------------
`define PMR_STAT_CAPS    16'h7808
`define PMR_SB_ANDONE    5
`define PMR_SB_FEF       4
`define PMR_SB_LINK      2
`define PMR_ADV_WMASK    16'h05E0
`define PMR_ADV_RST      16'h05E0
`define PMR_ADV_SEL      16'h0001
`define PMR_AB_PAUSE     10
`define PMR_AB_LO        5

// ---------------------------------------------------------------
// serial management framing
// ---------------------------------------------------------------
`define PMR_MD_PRE       6'd32
`define PMR_MD_HDR_LAST  6'd13
`define PMR_MD_TA_LAST   6'd14
`define PMR_MD_D0_LAST   6'd30
`define PMR_MD_END       6'd31
`define PMR_MD_ST        2'b01
`define PMR_MD_OP_RD     2'b10
`define PMR_MD_OP_WR     2'b01

// ---------------------------------------------------------------
// spi framing
// ---------------------------------------------------------------
`define PMR_SPI_WR       8'h02
`define PMR_SPI_RD       8'h03
`define PMR_SPI_HDR_LAST 5'd15
`define PMR_SPI_DAT_1ST  5'd17
`define PMR_SPI_END      5'd23
`define PMR_SPI_SAT      5'd31

`endif

//--- bench/pmr_checker.sv
`timescale 1ns/1ns
module pmr_checker (
  input wire       I_SYS_CLK,
  input wire       I_NRST,
  input wire       I_SPI_SS_N,
  input wire [4:0] I_NEG_SPEED_100,
  input wire [4:0] I_NEG_FULL_DPX,
  input wire       O_MDIO_OUT,
  input wire       O_MDIO_OE_N,
  input wire       O_SPI_MISO_OE_N,
  input wire [4:0] O_SOFT_RST,
  input wire [4:0] O_AN_RESTART,
  input wire [4:0] O_AN_ENABLE,
  input wire [4:0] O_LOOPBACK,
  input wire [4:0] O_SPEED_100,
  input wire [4:0] O_FULL_DPX
);
  reg [4:0] srst_q;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);

  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      srst_q <= 5'h00;
    end else begin
      srst_q <= O_SOFT_RST;
    end
  end

  // turnaround drives zero, then the line stays owned for at least eight clock cycles
  sequence s_ta_start;
    $fell(O_MDIO_OE_N) ##0 !O_MDIO_OUT;
  endsequence
  sequence s_held;
    (!O_MDIO_OE_N) [*8];
  endsequence

  ta_zero_a: assert property ($fell(O_MDIO_OE_N) |-> s_ta_start)
    else $error("turnaround bit not driven low");
  drive_hold_a: assert property ($fell(O_MDIO_OE_N) |-> s_held)
    else $error("read data drive released too early");
  idle_high_a: assert property (O_MDIO_OE_N |-> O_MDIO_OUT)
    else $error("data out not high while released");
  miso_off_a: assert property (I_SPI_SS_N [*4] |-> O_SPI_MISO_OE_N)
    else $error("spi output driven while deselected");
  srst_pulse_a: assert property (|O_SOFT_RST |=> O_SOFT_RST == 5'h00)
    else $error("soft reset pulse longer than one cycle");
  srst_dflt_a: assert property (|srst_q |-> ((O_AN_ENABLE & srst_q) == srst_q)
    && ((O_LOOPBACK & srst_q) == 5'h00))
    else $error("soft reset did not restore control defaults");
  anr_pulse_a: assert property (|O_AN_RESTART |->
    (O_AN_RESTART & O_SOFT_RST) == 5'h00 ##1 O_AN_RESTART == 5'h00)
    else $error("negotiation restart pulse wrong");
  neg_spd_a: assert property ($past(I_NRST) |->
    ((O_SPEED_100 ^ $past(I_NEG_SPEED_100)) & $past(O_AN_ENABLE)) == 5'h00)
    else $error("speed not following negotiation");
  neg_fdx_a: assert property ($past(I_NRST) |->
    ((O_FULL_DPX ^ $past(I_NEG_FULL_DPX)) & $past(O_AN_ENABLE)) == 5'h00)
    else $error("duplex not following negotiation");
endmodule

//--- bench/pmr_station.sv
`timescale 1ns/1ns
module pmr_station (
  input  wire i_clk,
  input  wire i_mdio_oe_n,
  input  wire i_mdio_out,
  input  wire i_miso,
  output reg  o_mdc,
  output wire o_mdio,
  output reg  o_sck,
  output reg  o_ss_n,
  output reg  o_mosi
);
  reg drv_en;
  reg drv_bit;

  // pulled-up line: reads high whenever nobody drives it
  assign o_mdio = !i_mdio_oe_n ? i_mdio_out : (drv_en ? drv_bit : 1'b1);

  initial begin
    drv_en = 1'b0;
    drv_bit = 1'b1;
    o_mdc = 1'b0;
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // 400 ns clock period; data moves while the clock is low, read just before it rises
  task automatic md_bit(input logic b, input logic en, output logic s);
    drv_en <= en;
    drv_bit <= b;
    cyc(4);
    s = o_mdio;
    o_mdc <= 1'b1;
    cyc(4);
    o_mdc <= 1'b0;
  endtask

  // full preamble before every frame; reads let go from the turnaround
  task automatic md_xfer(input logic wr, input logic [4:0] ph, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    logic        s;
    f = {2'b01, wr ? 2'b01 : 2'b10, ph, rg, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      md_bit(1'b1, 1'b1, s);
    end
    for (int i = 1; i <= 32; i++) begin
      md_bit(f[32-i], wr || i < 15, s);
      if (i >= 17) begin
        rd[32-i] = s;
      end
    end
    drv_en <= 1'b0;
    cyc(1);
  endtask

  // mode 0, msb first; clock stands still between frames
  task automatic spi_xfer(input logic [23:0] w, output logic [7:0] r);
    o_ss_n <= 1'b0;
    cyc(4);
    for (int i = 23; i >= 0; i--) begin
      o_mosi <= w[i];
      cyc(4);
      if (i < 8) begin
        r[i] = i_miso;
      end
      o_sck <= 1'b1;
      cyc(4);
      o_sck <= 1'b0;
    end
    cyc(4);
    o_ss_n <= 1'b1;
    o_mosi <= ~o_mosi;
    cyc(8);
  endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ns
module tb;
  localparam logic [15:0] ID_HI = 16'h1357; // arbitrary value
  localparam logic [15:0] ID_LO = 16'h2468; // arbitrary value
  logic        sys_clk;
  logic        nrst;
  logic [4:0]  link_up;
  logic [4:0]  an_done;
  logic [4:0]  far_flt;
  logic [4:0]  neg_spd;
  logic [4:0]  neg_fdx;
  logic [24:0] lp_abil;
  logic [4:0]  seen_sr;
  logic [4:0]  seen_ar;
  logic [15:0] rv;
  logic [7:0]  sv;
  wire         mdc, mdio, mdio_out, mdio_oe_n, sck, ss_n, mosi, miso, miso_oe_n;
  wire  [4:0]  sr, ar, lb, ae, pd, iso, fm, mx, fd, td, ld, sp, fx;
  wire  [24:0] adv;
  int          bad_count = 0;
  int          samples_checked = 0;

  pmr_phy_mgmt_regs #(.PHY_ID_HI(ID_HI), .PHY_ID_LO(ID_LO)) dut_u (
    .I_SYS_CLK(sys_clk), .I_NRST(nrst), .I_MDC(mdc), .I_MDIO_IN(mdio),
    .O_MDIO_OUT(mdio_out), .O_MDIO_OE_N(mdio_oe_n), .I_SPI_SCK(sck), .I_SPI_SS_N(ss_n),
    .I_SPI_MOSI(mosi), .O_SPI_MISO(miso), .O_SPI_MISO_OE_N(miso_oe_n),
    .I_LINK_UP(link_up), .I_AN_DONE(an_done), .I_FAR_FAULT(far_flt), .I_LP_ABIL(lp_abil),
    .I_NEG_SPEED_100(neg_spd), .I_NEG_FULL_DPX(neg_fdx), .O_SOFT_RST(sr),
    .O_AN_RESTART(ar), .O_LOOPBACK(lb), .O_AN_ENABLE(ae), .O_PWR_DOWN(pd),
    .O_ISOLATE(iso), .O_FORCE_MDI(fm), .O_AUTO_MDIX_DIS(mx), .O_FEF_DIS(fd),
    .O_TX_DIS(td), .O_LED_DIS(ld), .O_SPEED_100(sp), .O_FULL_DPX(fx), .O_ADV_ABIL(adv));

  // released spi output shows the inverse, so a late enable spoils the read byte
  pmr_station st_u (.i_clk(sys_clk), .i_mdio_oe_n(mdio_oe_n), .i_mdio_out(mdio_out),
    .i_miso(miso_oe_n ? ~miso : miso), .o_mdc(mdc), .o_mdio(mdio), .o_sck(sck),
    .o_ss_n(ss_n), .o_mosi(mosi));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // pulses last one cycle, so keep a sticky copy for the checks
  always @(posedge sys_clk) begin
    seen_sr <= seen_sr | sr;
    seen_ar <= seen_ar | ar;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL at %0t: got 0x%h, expected 0x%h", $time, got, exp);
    end
  endtask

  task automatic mw(input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
    st_u.md_xfer(1'b1, p, r, d, rv);
    st_u.cyc(4);
  endtask

  task automatic mr(input logic [4:0] p, input logic [4:0] r, input logic [15:0] e);
    st_u.md_xfer(1'b0, p, r, 16'h0000, rv);
    chk(rv, e);
  endtask

  task automatic t_defaults;
    logic [15:0] dv [0:5];
    dv = '{16'h3000, 16'h7808, ID_HI, ID_LO, 16'h05E1, 16'h0001};
    for (int p = 1; p <= 5; p++) begin
      for (int r = 0; r <= 5; r++) begin
        mr(p[4:0], r[4:0], dv[r]);
      end
    end
    chk({ae, lb, pd, iso}, {5'h1F, 15'h0000});
    chk({fm, mx, fd, td, ld}, 25'h0000000);
    chk(adv, 25'h1FFFFFF);
    chk({sp, fx}, {neg_spd, neg_fdx});
    $display("test defaults done");
  endtask

  task automatic t_range;
    mr(5'h00, 5'h00, 16'hFFFF);
    mr(5'h06, 5'h01, 16'hFFFF);
    mw(5'h00, 5'h00, 16'h0000);
    mr(5'h01, 5'h00, 16'h3000);
    mr(5'h02, 5'h06, 16'h0000);
    mr(5'h02, 5'h08, 16'h0000);
    mw(5'h02, 5'h1F, 16'hFFFF);
    mr(5'h02, 5'h00, 16'h3000);
    $display("test address range done");
  endtask

  task automatic t_ctrl;
    mw(5'h03, 5'h00, 16'h7FFF);
    chk(seen_ar, 5'h04);
    mr(5'h03, 5'h00, 16'h7D1F);
    chk({lb[2], pd[2], iso[2], fm[2], mx[2], fd[2], td[2], ld[2]}, 8'hFF);
    chk({lb, ld}, 10'h084);
    mw(5'h03, 5'h00, 16'h2100);
    chk({ae[2], sp[2], fx[2]}, 3'b011);
    mw(5'h03, 5'h00, 16'h0000);
    chk({ae[2], sp[2], fx[2], lb[2], iso[2], ld[2]}, 6'h00);
    mw(5'h03, 5'h00, 16'h8000);
    chk(seen_sr, 5'h04);
    mr(5'h03, 5'h00, 16'h3000);
    chk({ae[2], sp[2], fx[2]}, 3'b110);
    $display("test control done");
  endtask

  task automatic t_status;
    link_up <= 5'h02;
    an_done <= 5'h02;
    far_flt <= 5'h02;
    mr(5'h02, 5'h01, 16'h783C);
    mr(5'h03, 5'h01, 16'h7808);
    mw(5'h02, 5'h00, 16'h3004);
    mr(5'h02, 5'h01, 16'h782C);
    link_up <= 5'h00;
    far_flt <= 5'h00;
    neg_spd <= 5'h0A;
    neg_fdx <= 5'h15;
    mr(5'h02, 5'h01, 16'h7828);
    chk({sp, fx}, 10'h155);
    $display("test status done");
  endtask

  task automatic t_adv;
    mw(5'h04, 5'h04, 16'hFFFF);
    mr(5'h04, 5'h04, 16'h05E1);
    mw(5'h04, 5'h04, 16'h01E0);
    mr(5'h04, 5'h04, 16'h01E1);
    chk(adv[19:15], 5'h0F);
    mw(5'h04, 5'h02, 16'h0000);
    mr(5'h04, 5'h02, ID_HI);
    mw(5'h04, 5'h05, 16'hFFFF);
    lp_abil <= 25'h1F00000;
    mr(5'h05, 5'h05, 16'h05E1);
    mr(5'h04, 5'h05, 16'h0001);
    $display("test abilities done");
  endtask

  task automatic t_spi;
    st_u.spi_xfer({8'h02, 8'h11, 8'h1F}, sv);
    st_u.cyc(4);
    mr(5'h01, 5'h00, 16'h301F);
    st_u.spi_xfer({8'h03, 8'h10, 8'h00}, sv);
    chk(sv, 8'h30);
    st_u.spi_xfer({8'h03, 8'h13, 8'h00}, sv);
    chk(sv, 8'h08);
    $display("test spi done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    {link_up, an_done, far_flt} = 15'h0000;
    neg_spd = 5'h15;
    neg_fdx = 5'h0A;
    lp_abil = 25'h0000000;
    {seen_sr, seen_ar} = 10'h000;
    st_u.cyc(6);
    nrst <= 1'b1;
    st_u.cyc(4);
    t_defaults();
    t_range();
    t_ctrl();
    t_status();
    t_adv();
    t_spi();
    print_verdict();
  end

  // about 1.6 ms of frames are expected
  initial begin
    #3000000;
    bad_count++;
    print_verdict();
  end
endmodule

bind pmr_phy_mgmt_regs pmr_checker chk_u (
  .I_SYS_CLK, .I_NRST, .I_SPI_SS_N, .I_NEG_SPEED_100, .I_NEG_FULL_DPX, .O_MDIO_OUT,
  .O_MDIO_OE_N, .O_SPI_MISO_OE_N, .O_SOFT_RST, .O_AN_RESTART, .O_AN_ENABLE,
  .O_LOOPBACK, .O_SPEED_100, .O_FULL_DPX
);
